//--- verilog/bss_map.vh
// Constants for the two-word-burst SRAM synchronous port
`ifndef BSS_MAP_VH
`define BSS_MAP_VH

// ----------------------------------------------------------------
// Organisation
// ----------------------------------------------------------------
`define BSS_LANE_W      9
`define BSS_LANES       4
`define BSS_ADDR_W      21
`define BSS_BURST_SEED  1
`define BSS_BURST_LEN   2'h2

// ----------------------------------------------------------------
// Read buffer and pin synchroniser
// ----------------------------------------------------------------
`define BSS_FIFO_DEPTH  4
`define BSS_SYNC_STAGES 2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define BSS_DQ_RST      36'h0_0000_0000
`define BSS_OE_OFF      1'b1
`define BSS_OE_ON       1'b0

`endif

//--- verilog/bss_fifo.v
// Small synchronous FIFO carrying read beats to the data pins
`default_nettype none

module bss_fifo #(
    parameter WIDTH = 36,
    parameter DEPTH = 4,
    parameter PTR_W = 2
) (
    // Clock and reset
    input  wire             sys_clk,
    input  wire             arst_n,
    // Fill side
    input  wire             inValid,
    output wire             inReady,
    input  wire [WIDTH-1:0] inData,
    // Drain side
    output wire             outValid,
    input  wire             outReady,
    output wire [WIDTH-1:0] outData
);

    // ------------------------------------------------------------
    // Storage and pointers
    // ------------------------------------------------------------
    reg [WIDTH-1:0] store [0:DEPTH-1];
    reg [PTR_W-1:0] wrPtr;
    reg [PTR_W-1:0] rdPtr;
    reg [PTR_W:0]   count;

    wire doPush;
    wire doPop;

    // Full and empty come straight from the occupancy count
    assign inReady  = (count != DEPTH[PTR_W:0]);
    assign outValid = (count != {(PTR_W+1){1'b0}});
    assign outData  = store[rdPtr];
    assign doPush   = inValid && inReady;
    assign doPop    = outValid && outReady;

    // ------------------------------------------------------------
    // Pointer and count update
    // ------------------------------------------------------------
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wrPtr <= {PTR_W{1'b0}};
            rdPtr <= {PTR_W{1'b0}};
            count <= {(PTR_W+1){1'b0}};
        end else begin
            if (doPush) begin
                wrPtr <= (wrPtr == DEPTH[PTR_W-1:0] - 1'b1) ? {PTR_W{1'b0}} : wrPtr + 1'b1;
            end
            if (doPop) begin
                rdPtr <= (rdPtr == DEPTH[PTR_W-1:0] - 1'b1) ? {PTR_W{1'b0}} : rdPtr + 1'b1;
            end
            if (doPush && !doPop) begin
                count <= count + 1'b1;
            end else if (doPop && !doPush) begin
                count <= count - 1'b1;
            end
        end
    end

    // Data words need no reset
    always @(posedge sys_clk) begin
        if (doPush) begin
            store[wrPtr] <= inData;
        end
    end

endmodule // bss_fifo

`default_nettype wire

//--- verilog/bss_sram_port.v
// Synchronous command, address, byte-write and data port of a two-word-burst SRAM
//
// Operation
// - Each loaded address moves exactly two data words, read or write.
// - Lane selects are sampled at rising edges of both input clocks.
// - A deselected lane drops its data; the stored byte stays unchanged.
// - Select 0..3 govern nine-bit lanes [8:0], [17:9], [26:18], [35:27].
// - Each lane select is taken on the same edge as its data beat.
// - One address bus carries read and write addresses in turn.
// - Narrow organisations force internal address lsb to zero.
// - Wide organisations seed the one-bit burst counter from burst_lsb_in.
// - Wide organisations use 22 or 21 address inputs including the lsb.
// - Address inputs are ignored in cycles with no load.
// - With load low, dir_select high means read, low means write.
// - Read data is launched by the output clock pair when supplied.
// - Inputs are captured and accesses begin at rising in_timing_pos.
// - Rising in_timing_neg captures the write beat presented then.
// - In single clock mode read data follows the input clock pair.
// - Data outputs float from the first output edge that finds no read beat queued.
`default_nettype none
`include "bss_map.vh"

module bss_sram_port #(
    parameter LANE_W     = `BSS_LANE_W,
    parameter LANES      = `BSS_LANES,
    parameter ADDR_W     = `BSS_ADDR_W,
    parameter BURST_SEED = `BSS_BURST_SEED,
    parameter FIFO_DEPTH = `BSS_FIFO_DEPTH
) (
    // Clock and reset
    input  wire                      sys_clk,
    input  wire                      arst_n,
    // Input and output clock pairs, sampled as pins
    input  wire                      in_timing_pos,
    input  wire                      in_timing_neg,
    input  wire                      out_timing_pos,
    input  wire                      out_timing_neg,
    input  wire                      singleClkMode,
    // Command and address
    input  wire                      load_strobe_n,
    input  wire                      dir_select,
    input  wire [ADDR_W-2:0]         addrIn,
    input  wire                      burst_lsb_in,
    input  wire [LANES-1:0]          lane_write_sel_n,
    // Shared data pins
    input  wire [LANES*LANE_W-1:0]   dqIn,
    output reg  [LANES*LANE_W-1:0]   dqOut,
    output reg                       dqOe_n
);

    // ------------------------------------------------------------
    // Derived sizes and states
    // ------------------------------------------------------------
    localparam DATA_W = LANES * LANE_W;
    localparam IDX_W  = ADDR_W + 1;
    localparam SYNC_W = 5 + 2 + (ADDR_W - 1) + 1 + LANES + DATA_W;

    localparam [2:0] W_IDLE  = 3'b001;
    localparam [2:0] W_BEAT0 = 3'b010;
    localparam [2:0] W_BEAT1 = 3'b100;

    // ------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------
    // All pins share one two-flop chain, so clock edges and the data that
    // rides on them stay aligned after the crossing.
    // Limitation: each pin must hold for three cycles around a clock change.
    wire [SYNC_W-1:0] pinBus;
    reg  [SYNC_W-1:0] syncA;
    reg  [SYNC_W-1:0] syncB;

    assign pinBus = {in_timing_pos, in_timing_neg, out_timing_pos, out_timing_neg,
                     singleClkMode, load_strobe_n, dir_select, addrIn, burst_lsb_in,
                     lane_write_sel_n, dqIn};

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            syncA <= {SYNC_W{1'b0}};
            syncB <= {SYNC_W{1'b0}};
        end else begin
            syncA <= pinBus;
            syncB <= syncA;
        end
    end

    wire              kPos   = syncB[SYNC_W-1];
    wire              kNeg   = syncB[SYNC_W-2];
    wire              cPos   = syncB[SYNC_W-3];
    wire              cNeg   = syncB[SYNC_W-4];
    wire              single = syncB[SYNC_W-5];
    wire              ldN    = syncB[SYNC_W-6];
    wire              dirRd  = syncB[SYNC_W-7];
    wire [ADDR_W-2:0] addrS  = syncB[SYNC_W-8 -: ADDR_W-1];
    wire              lsbS   = syncB[LANES+DATA_W];
    wire [LANES-1:0]  laneS  = syncB[DATA_W +: LANES];
    wire [DATA_W-1:0] dataS  = syncB[DATA_W-1:0];

    // ------------------------------------------------------------
    // Clock edge detection
    // ------------------------------------------------------------
    reg kPosPrev;
    reg kNegPrev;
    reg cPosPrev;
    reg cNegPrev;

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            kPosPrev <= 1'b0;
            kNegPrev <= 1'b0;
            cPosPrev <= 1'b0;
            cNegPrev <= 1'b0;
        end else begin
            kPosPrev <= kPos;
            kNegPrev <= kNeg;
            cPosPrev <= cPos;
            cNegPrev <= cNeg;
        end
    end

    // The synchroniser resets to zero, so a pin that idles high would look
    // like a rising edge once its real level arrives; edges wait for warm-up.
    reg [2:0] warmUp;
    wire      primed = warmUp[2];

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            warmUp <= 3'h0;
        end else begin
            warmUp <= {warmUp[1:0], 1'b1};
        end
    end

    wire kPosRise = primed && kPos && !kPosPrev;
    wire kNegRise = primed && kNeg && !kNegPrev;
    wire cPosRise = primed && cPos && !cPosPrev;
    wire cNegRise = primed && cNeg && !cNegPrev;

    // Output pair launches reads, or the input pair in single clock mode
    wire outEdge = single ? (kPosRise || kNegRise)
                          : (cPosRise || cNegRise);

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    // Only a load taken on rising in_timing_pos starts an access; the
    // address bus is not looked at in any other cycle.
    wire loadNow  = kPosRise && !ldN;
    wire loadRead = loadNow && dirRd;
    wire loadWr   = loadNow && !dirRd;

    // Burst counter seed: from the pin on wide parts, zero on narrow parts
    wire seedNow  = (BURST_SEED != 0) ? lsbS : 1'b0;

    // Upper index bits: on wide parts burst_lsb_in is the counter itself,
    // on narrow parts it is one more address bit above the forced zero.
    wire [IDX_W-2:0] baseNow = (BURST_SEED != 0) ? {1'b0, addrS}
                                                 : {addrS, lsbS};

    // ------------------------------------------------------------
    // Storage array
    // ------------------------------------------------------------
    reg [DATA_W-1:0] mem [0:(1<<IDX_W)-1];

    // ------------------------------------------------------------
    // Write sequencer
    // ------------------------------------------------------------
    reg [2:0]        wState;
    reg [2:0]        next_wState;
    reg [IDX_W-2:0]  wBase;
    reg              wCnt;
    reg              wrEn;
    reg [IDX_W-1:0]  wrIdx;

    // First beat on the next rising in_timing_neg, second on the
    // rising in_timing_pos after it; each beat takes its own lane selects.
    always @* begin
        next_wState = wState;
        wrEn        = 1'b0;
        wrIdx       = {wBase, wCnt};
        case (wState)
            W_IDLE: begin
                if (loadWr) begin
                    next_wState = W_BEAT0;
                end
            end
            W_BEAT0: begin
                if (kNegRise) begin
                    wrEn        = 1'b1;
                    wrIdx       = {wBase, wCnt};
                    next_wState = W_BEAT1;
                end
            end
            W_BEAT1: begin
                if (kPosRise) begin
                    wrEn        = 1'b1;
                    wrIdx       = {wBase, ~wCnt};
                    next_wState = loadWr ? W_BEAT0 : W_IDLE;
                end
            end
            default: begin
                next_wState = W_IDLE;
            end
        endcase
    end

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wState <= W_IDLE;
            wBase  <= {(IDX_W-1){1'b0}};
            wCnt   <= 1'b0;
        end else begin
            wState <= next_wState;
            if (loadWr) begin
                wBase <= baseNow;
                wCnt  <= seedNow;
            end
        end
    end

    // Byte-lane write: a lane whose select is high keeps its old contents
    integer ln;
    always @(posedge sys_clk) begin
        if (wrEn) begin
            for (ln = 0; ln < LANES; ln = ln + 1) begin
                if (!laneS[ln]) begin
                    mem[wrIdx][ln*LANE_W +: LANE_W] <= dataS[ln*LANE_W +: LANE_W];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Read sequencer
    // ------------------------------------------------------------
    reg [1:0]        rLeft;
    reg [IDX_W-2:0]  rBase;
    reg              rCnt;
    wire             fifoInReady;
    wire             rPush = (rLeft != 2'd0);
    wire [IDX_W-1:0] rdIdx = {rBase, rCnt};

    // Two pushes per read; a full buffer holds the sequencer back.
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rLeft <= 2'd0;
            rBase <= {(IDX_W-1){1'b0}};
            rCnt  <= 1'b0;
        end else if (loadRead) begin
            rLeft <= `BSS_BURST_LEN;
            rBase <= baseNow;
            rCnt  <= seedNow;
        end else if (rPush && fifoInReady) begin
            rLeft <= rLeft - 2'd1;
            rCnt  <= ~rCnt;
        end
    end

    // ------------------------------------------------------------
    // Read buffer
    // ------------------------------------------------------------
    wire              fifoOutValid;
    wire [DATA_W-1:0] fifoOutData;
    wire              fifoPop = outEdge;

    // Four entries leave room for a second burst queued behind the first
    bss_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH),
        .PTR_W (2)
    ) uFifo (
        .sys_clk  (sys_clk),
        .arst_n   (arst_n),
        .inValid  (rPush),
        .inReady  (fifoInReady),
        .inData   (mem[rdIdx]),
        .outValid (fifoOutValid),
        .outReady (fifoPop),
        .outData  (fifoOutData)
    );

    // ------------------------------------------------------------
    // Data pin driver
    // ------------------------------------------------------------
    // Each output edge launches the next beat; an edge with nothing
    // queued releases the pins, so they float between reads.
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            dqOut  <= `BSS_DQ_RST;
            dqOe_n <= `BSS_OE_OFF;
        end else if (outEdge) begin
            if (fifoOutValid) begin
                dqOut  <= fifoOutData;
                dqOe_n <= `BSS_OE_ON;
            end else begin
                dqOe_n <= `BSS_OE_OFF;
            end
        end
    end

endmodule // bss_sram_port

`default_nettype wire

//--- sim/bss_port_properties.sv
// Concurrent checks on the pins of the SRAM synchronous port
`default_nettype none
module bss_port_properties #(
    parameter LANE_W = 9,
    parameter LANES  = 4
) (
    // Clock and reset
    input wire logic                    sys_clk,
    input wire logic                    arst_n,
    // Clock pins and command
    input wire logic                    in_timing_pos,
    input wire logic                    in_timing_neg,
    input wire logic                    out_timing_pos,
    input wire logic                    out_timing_neg,
    input wire logic                    singleClkMode,
    input wire logic                    load_strobe_n,
    input wire logic                    dir_select,
    // Data pins
    input wire logic [LANES*LANE_W-1:0] dqOut,
    input wire logic                    dqOe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // Edge tracking on raw pins; the port lags it by its sync pipeline
    // ----
    logic [3:0] prev;
    logic [3:0] cntC;
    logic [3:0] cntK;
    logic [1:0] beats;
    wire logic [3:0] pins = {out_timing_neg, out_timing_pos, in_timing_neg, in_timing_pos};
    wire logic [3:0] rise = pins & ~prev;
    wire logic oEdge = singleClkMode ? |rise[1:0] : |rise[3:2];
    wire logic readLoad = rise[0] & ~load_strobe_n & dir_select;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            prev    <= 4'hf;
            cntC    <= 4'hf;
            cntK    <= 4'hf;
            beats   <= 2'h0;
        end else begin
            prev    <= pins;
            cntC    <= (|rise[3:2]) ? 4'h0 : cntC + {3'h0, cntC != 4'hf};
            cntK    <= (|rise[1:0]) ? 4'h0 : cntK + {3'h0, cntK != 4'hf};
            beats   <= readLoad ? 2'h2 : beats - {1'b0, oEdge && beats != 2'h0};
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    reset_idle_a: assert property (
        $rose(arst_n) |-> dqOe_n && dqOut == '0) else $error("Pins not idle after reset");
    outpair_launch_a: assert property (
        !singleClkMode && ($changed(dqOut) || $changed(dqOe_n)) |-> cntC < 4'h6)
        else $error("Read pins moved without an output pair edge");
    inpair_launch_a: assert property (
        singleClkMode && ($changed(dqOut) || $changed(dqOe_n)) |-> cntK < 4'h6)
        else $error("Read pins moved without an input pair edge");
    empty_release_a: assert property (
        oEdge && beats == 2'h0 |-> ##[2:5] dqOe_n) else $error("Pins not released");
    beat_drive_a: assert property (
        oEdge && beats != 2'h0 |-> ##[2:5] !dqOe_n) else $error("Read beat not driven");
    beat_hold_a: assert property (
        $fell(dqOe_n) |-> !dqOe_n [*4]) else $error("Drive dropped early");
    data_hold_a: assert property (
        $changed(dqOut) |=> $stable(dqOut) [*3]) else $error("Read word not held");
    read_only_a: assert property (
        $fell(dqOe_n) |-> $past(beats, 3) != 2'h0) else $error("Pins driven without a read");
endmodule // bss_port_properties
bind bss_sram_port bss_port_properties #(.LANE_W(LANE_W), .LANES(LANES)) bss_port_properties_i (
    .sys_clk(sys_clk), .arst_n(arst_n), .in_timing_pos(in_timing_pos),
    .in_timing_neg(in_timing_neg), .out_timing_pos(out_timing_pos),
    .out_timing_neg(out_timing_neg), .singleClkMode(singleClkMode),
    .load_strobe_n(load_strobe_n), .dir_select(dir_select), .dqOut(dqOut), .dqOe_n(dqOe_n));
`default_nettype wire

//--- sim/bss_ctrl_model.sv
// Memory controller model driving clock pins, command and data
`default_nettype none
module bss_ctrl_model (
    // Clock
    input  wire logic        sys_clk,
    // Towards the port
    output var  logic        kPos,
    output var  logic        kNeg,
    output var  logic        oPos,
    output var  logic        oNeg,
    output var  logic        ldN,
    output var  logic        dir,
    output var  logic [4:0]  addr,
    output var  logic        lsb,
    output var  logic [3:0]  sel,
    output wire logic [35:0] dqIn,
    // From the port
    input  wire logic [35:0] dqOut,
    input  wire logic        dqOe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [35:0] drv;
    // Shared pins show the port's word while it drives, else ours
    assign dqIn = (dqOe_n === 1'b0) ? dqOut : drv;
    initial begin
        kPos = 1'b0;
        kNeg = 1'b1;
        oPos = 1'b0;
        oNeg = 1'b1;
        ldN  = 1'b1;
        dir  = 1'b0;
        addr = 5'h0;
        lsb  = 1'b0;
        sel  = 4'hf;
        drv  = 36'h0_0000_0000;
    end
    // Pins settle 3 cycles before a pair toggles and hold 5 after, so the
    // port's sync pipeline sees them stable; one shared address bus
    // Load, direction, lane selects and data ride the same edge
    task automatic step(input logic o, input logic l, input logic r, input logic [5:0] a,
                        input logic [3:0] s, input logic [35:0] d);
        @(posedge sys_clk);
        ldN  <= l;
        dir  <= r;
        {addr, lsb} <= a;
        sel  <= s;
        drv  <= d;
        repeat (3) @(posedge sys_clk);
        if (o) begin
            oPos <= ~oPos;
            oNeg <= oPos;
        end else begin
            kPos <= ~kPos;
            kNeg <= kPos;
        end
        repeat (5) @(posedge sys_clk);
    endtask
endmodule // bss_ctrl_model
`default_nettype wire

//--- sim/bss_sram_port_tb.sv
// Self-checking bench for the SRAM port with a behavioural memory model
`default_nettype none
module bss_sram_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sysClk;
    logic        arstN;
    logic        single;
    logic        kPos, kNeg, oPos, oNeg, ldN, dir, lsb;
    logic [4:0]  addr;
    logic [3:0]  sel;
    logic [35:0] dqIn, dqOut;
    logic        dqOe_n;
    logic [35:0] mem [64];
    integer      seed = 32'h5f78850d;
    integer      bad_count = 0;
    integer      check_count = 0;
    integer      i;
    logic [35:0] t;
    bss_sram_port #(.ADDR_W(6)) bss_sram_port_i (
        .sys_clk(sysClk), .arst_n(arstN), .in_timing_pos(kPos), .in_timing_neg(kNeg),
        .out_timing_pos(oPos), .out_timing_neg(oNeg), .singleClkMode(single),
        .load_strobe_n(ldN), .dir_select(dir), .addrIn(addr), .burst_lsb_in(lsb),
        .lane_write_sel_n(sel), .dqIn(dqIn), .dqOut(dqOut), .dqOe_n(dqOe_n));
    bss_ctrl_model bss_ctrl_model_i (
        .sys_clk(sysClk), .kPos(kPos), .kNeg(kNeg), .oPos(oPos), .oNeg(oNeg), .ldN(ldN),
        .dir(dir), .addr(addr), .lsb(lsb), .sel(sel), .dqIn(dqIn), .dqOut(dqOut),
        .dqOe_n(dqOe_n));
    function automatic logic [35:0] rnd();
        logic [63:0] r;
        r = {$random(seed), $random(seed)};
        return r[35:0];
    endfunction
    function automatic logic [35:0] lm(input logic [3:0] s);
        for (int k = 0; k < 4; k++) lm[9*k +: 9] = {9{~s[k]}};
    endfunction
    task automatic chk(input string n, input logic [35:0] s, input logic [35:0] e);
        check_count++;
        if (s !== e) begin
            bad_count++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic close_out();
        $display("Checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Random address pins off the load edge must not matter
    task automatic wr(input logic [5:0] a, input logic [3:0] s0, input logic [3:0] s1);
        logic [35:0] d0, d1;
        d0 = rnd();
        d1 = rnd();
        bss_ctrl_model_i.step(1'b0, 1'b0, 1'b0, a, 4'hf, rnd());
        bss_ctrl_model_i.step(1'b0, 1'b1, 1'b0, 6'(rnd()), s0, d0);
        bss_ctrl_model_i.step(1'b0, 1'b1, 1'b0, 6'(rnd()), s1, d1);
        bss_ctrl_model_i.step(1'b0, 1'b1, 1'b0, 6'(rnd()), 4'hf, rnd());
        mem[a] = (mem[a] & ~lm(s0)) | (d0 & lm(s0));
        mem[a ^ 6'h1] = (mem[a ^ 6'h1] & ~lm(s1)) | (d1 & lm(s1));
        #1 chk("oe after write", {35'h0, dqOe_n}, 36'h1);
    endtask
    task automatic rd(input logic [5:0] a);
        bss_ctrl_model_i.step(1'b0, 1'b0, 1'b1, a, 4'hf, rnd());
        for (int k = 0; k < 3; k++) begin
            if (!single && k == 0)
                bss_ctrl_model_i.step(1'b0, 1'b1, 1'b0, 6'(rnd()), 4'hf, rnd());
            bss_ctrl_model_i.step(!single, 1'b1, 1'b0, 6'(rnd()), 4'hf, rnd());
            #1;
            if (k < 2) begin
                chk("read word", dqOut, k == 0 ? mem[a] : mem[a ^ 6'h1]);
                chk("oe on beat", {35'h0, dqOe_n}, 36'h0);
            end else begin
                chk("oe after burst", {35'h0, dqOe_n}, 36'h1);
            end
        end
    endtask
    initial begin
        sysClk = 1'b0;
        forever #2.5 sysClk = ~sysClk;
    end
    initial begin
        repeat (20000) @(posedge sysClk);
        bad_count++;
        close_out();
    end
    initial begin
        arstN  = 1'b0;
        single = 1'b0;
        repeat (3) @(posedge sysClk);
        arstN <= 1'b1;
        for (i = 0; i < 8; i += 2) wr(i[5:0], 4'h0, 4'h0);
        $display("Test fill done");
        // Mixed reads and writes, both launch modes, random lanes and burst seed
        for (i = 0; i < 40; i++) begin
            t = rnd();
            @(posedge sysClk);
            single <= t[8];
            if (t[9]) rd({3'h0, t[2:0]});
            else wr({3'h0, t[2:0]}, t[7:4], t[13:10]);
        end
        $display("Test random traffic done");
        close_out();
    end
endmodule // bss_sram_port_tb
`default_nettype wire
